// >>> esfp_addsub.sv
// Purpose: truncating floating-point add/subtract for one format
// Assumes: denormals flushed to zero; nan and infinity handled by the caller
// Notes: guard and sticky come out for a rounding handler
`timescale 1ns/1ps
module esfp_addsub #(
    parameter int EW = 11,
    parameter int FW = 52
) (
    // operands, b negated when sub_en is high
    input wire logic [EW+FW:0] op_a,
    input wire logic [EW+FW:0] op_b,
    input wire logic sub_en,
    // truncated result and conditions
    output logic [EW+FW:0] res,
    output logic inexact,
    output logic guard,
    output logic sticky,
    output logic ovf,
    output logic unf
);
    localparam int MW = FW + 1;
    localparam int XW = 2 * MW;
    localparam int NW = XW + 1;
    localparam int LW = $clog2(NW + 1);

    function automatic logic [LW-1:0] lead_zeros(logic [NW-1:0] v);
        logic [LW-1:0] n;
        logic hit;
        n = '0;
        hit = 1'b0;
        for (int i = NW - 1; i >= 0; i--) begin
            hit = hit | v[i];
            if (!hit) begin
                n = n + LW'(1);
            end
        end
        return n;
    endfunction

    logic [EW+FW:0] bb;
    logic [EW+FW:0] big;
    logic [EW+FW:0] sml;
    logic swap;
    logic [EW-1:0] e_big;
    logic [EW-1:0] e_sml;
    logic [EW-1:0] diff;
    logic [XW-1:0] x_big;
    logic [XW-1:0] x_sml;
    logic [XW-1:0] x_shf;
    logic lost;
    logic eff_sub;
    logic zero;
    logic [NW-1:0] sum;
    logic [NW-1:0] norm;
    logic [LW-1:0] lz;
    logic signed [EW+1:0] r_exp;

    assign bb = {op_b[EW+FW] ^ sub_en, op_b[EW+FW-1:0]};
    assign swap = bb[EW+FW-1:0] > op_a[EW+FW-1:0];
    assign big = swap ? bb : op_a;
    assign sml = swap ? op_a : bb;
    assign e_big = big[EW+FW-1:FW];
    assign e_sml = sml[EW+FW-1:FW];
    assign diff = e_big - e_sml;
    // zero exponent flushes denormals to zero
    assign x_big = (e_big == '0) ? '0 : {1'b1, big[FW-1:0], {MW{1'b0}}};
    assign x_sml = (e_sml == '0) ? '0 : {1'b1, sml[FW-1:0], {MW{1'b0}}};
    assign x_shf = (32'(diff) >= XW) ? '0 : (x_sml >> diff);
    assign lost = (32'(diff) >= XW) ? |x_sml : |(x_sml & ~({XW{1'b1}} << diff));
    assign eff_sub = big[EW+FW] ^ sml[EW+FW];
    // borrow for lost bits so a difference truncates toward zero
    assign sum = eff_sub ? ({1'b0, x_big} - {1'b0, x_shf} - NW'(lost)) : ({1'b0, x_big} + {1'b0, x_shf});
    assign lz = lead_zeros(sum);
    assign norm = sum << lz;
    assign zero = (sum == '0);
    assign r_exp = $signed({2'b00, e_big}) + (EW+2)'(1) - $signed((EW+2)'(lz));
    assign ovf = !zero && (r_exp >= $signed({2'b00, {EW{1'b1}}}));
    assign unf = !zero && (r_exp <= $signed((EW+2)'(0)));
    assign guard = norm[NW-2-FW];
    assign sticky = lost | (|norm[NW-3-FW:0]);
    assign inexact = !zero && (guard || sticky);
    assign res = zero ? '0 : {big[EW+FW], r_exp[EW-1:0], norm[NW-2 -: FW]};
endmodule

// >>> esfp_core_model.sv
// Purpose: register file and condition register of the core behind the unit
// Assumes: writebacks arrive as single-cycle strobes from the unit
// Notes: low-word writes keep the upper half, as single ops demand
`timescale 1ns/1ps
module esfp_core_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // writeback from the unit
    input wire logic wb_gpr_we_q,
    input wire logic wb_lo_only_q,
    input wire logic [4:0] wb_gpr_idx_q,
    input wire logic [63:0] wb_gpr_data_q,
    input wire logic wb_cr_we_q,
    input wire logic [2:0] wb_cr_field_q,
    input wire logic [3:0] wb_cr_data_q
);
    logic [63:0] gpr_q [32];
    logic [31:0] cr_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cr_q <= 32'h0000_0000;
        end else begin
            // upper half of a register survives a single-precision result
            if (wb_gpr_we_q && wb_lo_only_q) gpr_q[wb_gpr_idx_q][31:0] <= wb_gpr_data_q[31:0];
            if (wb_gpr_we_q && !wb_lo_only_q) gpr_q[wb_gpr_idx_q] <= wb_gpr_data_q;
            if (wb_cr_we_q) cr_q[4*wb_cr_field_q +: 4] <= wb_cr_data_q;
        end
    end
endmodule

// >>> esfp_pkg.sv
// Purpose: shared constants and types for the sign, subtract and test unit
// Assumes: big-endian field numbers of the instruction set mapped to [31:0] and [63:0]
// Notes: status/control word is reached over apb at one aligned word
package esfp_pkg;
    // instruction word fields
    localparam logic [5:0] PRIMARY_OP = 6'h04;
    localparam int POP_HI = 31;
    localparam int POP_LO = 26;
    localparam int RD_HI = 25;
    localparam int RD_LO = 21;
    localparam int CRF_HI = 25;
    localparam int CRF_LO = 23;
    localparam int XO_HI = 10;
    localparam logic [10:0] XO_DNABS = 11'h2E5;
    localparam logic [10:0] XO_DNEG = 11'h2E6;
    localparam logic [10:0] XO_DSUB = 11'h2E1;
    localparam logic [10:0] XO_DTSTEQ = 11'h2FE;
    localparam logic [10:0] XO_DTSTGT = 11'h2FC;
    localparam logic [10:0] XO_DTSTLT = 11'h2FD;
    localparam logic [10:0] XO_SABS = 11'h2C4;
    localparam logic [10:0] XO_SADD = 11'h2C0;

    typedef enum logic [3:0] {
        OP_NONE, OP_DNABS, OP_DNEG, OP_DSUB, OP_DTSTEQ, OP_DTSTGT, OP_DTSTLT, OP_SABS, OP_SADD
    } esfp_op_t;

    // value layouts
    localparam int DP_SIGN = 63;
    localparam int DP_EXP_HI = 62;
    localparam int DP_EXP_LO = 52;
    localparam int DP_FRAC_HI = 51;
    localparam int SP_SIGN = 31;
    localparam int SP_EXP_HI = 30;
    localparam int SP_EXP_LO = 23;
    localparam int SP_FRAC_HI = 22;
    localparam int DP_EW = 11;
    localparam int DP_FW = 52;
    localparam int SP_EW = 8;
    localparam int SP_FW = 23;
    localparam logic [63:0] DP_PMAX = 64'h7FEF_FFFF_FFFF_FFFF;
    localparam logic [63:0] DP_SMASK = 64'h8000_0000_0000_0000;
    localparam logic [63:0] SP_PMAX = 64'h0000_0000_7F7F_FFFF;
    localparam logic [63:0] SP_SMASK = 64'h0000_0000_8000_0000;
    localparam logic [63:0] SP_LOMASK = 64'h0000_0000_FFFF_FFFF;

    // status/control word
    localparam logic [11:0] SCR_ADDR = 12'h000;
    localparam logic [31:0] SCR_RESET = 32'h0000_0000;
    localparam logic [31:0] SCR_WMASK = 32'h0000_7F3F;
    localparam int B_INV = 0;
    localparam int B_OVF = 1;
    localparam int B_UNF = 2;
    localparam int B_INXS = 3;
    localparam int B_G = 4;
    localparam int B_X = 5;
    localparam int B_INVE = 8;
    localparam int B_OVFE = 9;
    localparam int B_UNFE = 10;
    localparam int B_INXE = 11;
    localparam int B_RND_HI = 13;
    localparam int B_RND_LO = 12;
    localparam int B_DETECT = 14;
    localparam logic [1:0] RMODE_MINUS = 2'h3;
    localparam int CR_TEST_BIT = 2;
endpackage

// >>> esfp_unit.sv
// Purpose: sign, subtract, test-compare and single add slice of the fp unit
// Assumes: one instruction per issue cycle, result one clock later
// Notes: status/control word over apb; hardware flag sets win over writes
// What this block does
// - inexact or quiet overflow sets inexact sticky flag
// - inexact enabled: round interrupt, truncated write, guard
// - overflow, underflow, invalid clear guard and sticky-extra
// - negative abs forces sign one
// - negate inverts only the sign bit
// - invalid detection for sign ops is optional
// - without detection only the sign changes
// - detected special input sets invalid, may interrupt
// - subtract computes a minus b, saturating nan and infinity inputs
// - subtract underflow gives zero signed by mode
// - special subtract operand sets invalid flag
// - otherwise overflow or underflow flags get set
// - enabled overflow/underflow interrupts, destination untouched
// - tests set selected condition bit when true
// - tests treat plus and minus zero equal
// - tests use exponent and fraction fields directly
// - tests never change status flags
// - single abs clears the sign bit
// - single add sums the low words
// - single overflow or nan/infinity input gives signed maximum
// - single underflow gives signed zero
`timescale 1ns/1ps
module esfp_unit (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // issue from the core
    input wire logic iss_valid,
    input wire logic [esfp_pkg::POP_HI:0] iss_instr,
    input wire logic [esfp_pkg::DP_SIGN:0] iss_opa,
    input wire logic [esfp_pkg::DP_SIGN:0] iss_opb,
    // writeback
    output logic done_q,
    output logic unimp_q,
    output logic wb_gpr_we_q,
    output logic wb_lo_only_q,
    output logic [4:0] wb_gpr_idx_q,
    output logic [esfp_pkg::DP_SIGN:0] wb_gpr_data_q,
    output logic wb_cr_we_q,
    output logic [2:0] wb_cr_field_q,
    output logic [3:0] wb_cr_data_q,
    // interrupts toward the core
    output logic data_irq_q,
    output logic round_irq_q,
    output logic [31:0] fp_status_control_reg_q,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q
);
    import esfp_pkg::*;

    function automatic esfp_op_t dec_op(logic [31:0] i);
        if (i[POP_HI:POP_LO] != PRIMARY_OP) begin
            return OP_NONE;
        end
        case (i[XO_HI:0])
            XO_DNABS: return OP_DNABS;
            XO_DNEG: return OP_DNEG;
            XO_DSUB: return OP_DSUB;
            XO_DTSTEQ: return OP_DTSTEQ;
            XO_DTSTGT: return OP_DTSTGT;
            XO_DTSTLT: return OP_DTSTLT;
            XO_SABS: return OP_SABS;
            XO_SADD: return OP_SADD;
            default: return OP_NONE;
        endcase
    endfunction

    // {nan or infinity, any special}
    function automatic logic [1:0] fp_class(logic [63:0] v, logic sp);
        logic e1;
        logic e0;
        logic fnz;
        e1 = sp ? &v[SP_EXP_HI:SP_EXP_LO] : &v[DP_EXP_HI:DP_EXP_LO];
        e0 = sp ? ~|v[SP_EXP_HI:SP_EXP_LO] : ~|v[DP_EXP_HI:DP_EXP_LO];
        fnz = sp ? |v[SP_FRAC_HI:0] : |v[DP_FRAC_HI:0];
        return {e1, e1 | (e0 & fnz)};
    endfunction

    // sign-magnitude order on raw fields, zeros equal
    function automatic logic dp_gt(logic [63:0] x, logic [63:0] y);
        if (~|x[DP_EXP_HI:0] && ~|y[DP_EXP_HI:0]) begin
            return 1'b0;
        end
        if (x[DP_SIGN] != y[DP_SIGN]) begin
            return ~x[DP_SIGN];
        end
        return x[DP_SIGN] ? (y[DP_EXP_HI:0] > x[DP_EXP_HI:0]) : (x[DP_EXP_HI:0] > y[DP_EXP_HI:0]);
    endfunction

    logic [31:0] scr_q;
    logic [31:0] scr_d;
    esfp_op_t op;
    logic is_dsub;
    logic is_sadd;
    logic arith;
    logic sign_op;
    logic tst_op;
    logic inv_en;
    logic ovf_en;
    logic unf_en;
    logic inx_en;
    logic rnd_minus;
    logic [1:0] cls_a;
    logic [1:0] cls_b;
    logic [63:0] d_res;
    logic [31:0] s_res;
    logic d_inx, d_g, d_x, d_ovf, d_unf;
    logic s_inx, s_g, s_x, s_ovf, s_unf;

    assign op = dec_op(iss_instr);
    assign is_dsub = (op == OP_DSUB);
    assign is_sadd = (op == OP_SADD);
    assign arith = is_dsub | is_sadd;
    assign sign_op = (op == OP_DNABS) | (op == OP_DNEG) | (op == OP_SABS);
    assign tst_op = (op == OP_DTSTEQ) | (op == OP_DTSTGT) | (op == OP_DTSTLT);
    assign inv_en = scr_q[B_INVE];
    assign ovf_en = scr_q[B_OVFE];
    assign unf_en = scr_q[B_UNFE];
    assign inx_en = scr_q[B_INXE];
    assign rnd_minus = (scr_q[B_RND_HI:B_RND_LO] == RMODE_MINUS);
    assign cls_a = fp_class(iss_opa, !is_dsub && op != OP_DNABS && op != OP_DNEG);
    assign cls_b = fp_class(iss_opb, !is_dsub);

    esfp_addsub #(.EW(DP_EW), .FW(DP_FW)) u_dsub (
        .op_a(iss_opa),
        .op_b(iss_opb),
        .sub_en(1'b1),
        .res(d_res),
        .inexact(d_inx),
        .guard(d_g),
        .sticky(d_x),
        .ovf(d_ovf),
        .unf(d_unf)
    );

    esfp_addsub #(.EW(SP_EW), .FW(SP_FW)) u_sadd (
        .op_a(iss_opa[SP_SIGN:0]),
        .op_b(iss_opb[SP_SIGN:0]),
        .sub_en(1'b0),
        .res(s_res),
        .inexact(s_inx),
        .guard(s_g),
        .sticky(s_x),
        .ovf(s_ovf),
        .unf(s_unf)
    );

    // arithmetic path: shared exception handling for both formats
    logic ar_inv, ar_ovf, ar_unf, ar_inx, raw_ovf, raw_unf;
    logic a_ni, b_ni, a_s, b_s, ar_sign, sum_sign;
    logic [63:0] sum_val, ar_mag, ar_res, smask;
    assign a_ni = cls_a[1];
    assign b_ni = cls_b[1];
    assign a_s = is_dsub ? iss_opa[DP_SIGN] : iss_opa[SP_SIGN];
    assign b_s = is_dsub ? iss_opb[DP_SIGN] : iss_opb[SP_SIGN];
    assign sum_val = is_dsub ? d_res : {32'h0000_0000, s_res};
    assign sum_sign = is_dsub ? d_res[DP_SIGN] : s_res[SP_SIGN];
    assign smask = is_dsub ? DP_SMASK : SP_SMASK;
    assign raw_ovf = is_dsub ? d_ovf : s_ovf;
    assign raw_unf = is_dsub ? d_unf : s_unf;
    assign ar_inv = arith & (cls_a[0] | cls_b[0]);
    assign ar_ovf = arith & ~ar_inv & raw_ovf;
    assign ar_unf = arith & ~ar_inv & raw_unf;
    assign ar_inx = arith & ~ar_inv & ~raw_unf & (is_dsub ? d_inx : s_inx);
    // saturation and signed zeros
    assign ar_mag = (a_ni | b_ni | raw_ovf) ? (is_dsub ? DP_PMAX : SP_PMAX) :
                    raw_unf ? 64'h0000_0000_0000_0000 : (sum_val & ~smask);
    assign ar_sign = a_ni ? a_s : b_ni ? (b_s ^ is_dsub) : raw_unf ? rnd_minus : sum_sign;
    assign ar_res = ar_mag | (smask & {64{ar_sign}});

    // sign path; detection is a run-time option
    logic sop_inv;
    logic [63:0] sop_res;
    assign sop_inv = sign_op & scr_q[B_DETECT] & cls_a[0];
    assign sop_res = (op == OP_DNABS) ? (iss_opa | DP_SMASK) :
                     (op == OP_DNEG) ? (iss_opa ^ DP_SMASK) : (iss_opa & SP_LOMASK & ~SP_SMASK);

    // test compares read raw fields, no status effect
    logic cl;
    assign cl = (op == OP_DTSTEQ) ? ((iss_opa == iss_opb) || (~|iss_opa[DP_EXP_HI:0] && ~|iss_opb[DP_EXP_HI:0])) :
                (op == OP_DTSTGT) ? dp_gt(iss_opa, iss_opb) : dp_gt(iss_opb, iss_opa);

    // interrupt and writeback decisions
    logic data_irq_d, round_irq_d, inx_set, gx_clear, gx_load, gpr_we_d;
    assign data_irq_d = (ar_inv & inv_en) | (ar_ovf & ovf_en) | (ar_unf & unf_en) | (sop_inv & inv_en);
    assign inx_set = (ar_inx | (ar_ovf & ~ovf_en)) & ~data_irq_d;
    assign round_irq_d = inx_set & inx_en;
    assign gx_clear = ar_inv | ar_ovf | ar_unf | sop_inv;
    assign gx_load = arith & ~gx_clear;
    assign gpr_we_d = (arith | sign_op) & ~data_irq_d;

    // status/control next value; hardware sets override a same-cycle write
    logic apb_acc, apb_done, apb_hit;
    assign apb_acc = psel & penable;
    assign apb_done = apb_acc & pready_q;
    assign apb_hit = (paddr == SCR_ADDR);
    always_comb begin
        scr_d = scr_q;
        if (apb_done && pwrite && apb_hit) begin
            scr_d = pwdata & SCR_WMASK;
        end
        if (iss_valid) begin
            scr_d[B_INV] = scr_d[B_INV] | ar_inv | sop_inv;
            scr_d[B_OVF] = scr_d[B_OVF] | ar_ovf;
            scr_d[B_UNF] = scr_d[B_UNF] | ar_unf;
            scr_d[B_INXS] = scr_d[B_INXS] | inx_set;
            if (gx_clear) begin
                scr_d[B_G] = 1'b0;
                scr_d[B_X] = 1'b0;
            end else if (gx_load) begin
                scr_d[B_G] = is_dsub ? d_g : s_g;
                scr_d[B_X] = is_dsub ? d_x : s_x;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scr_q <= SCR_RESET;
        end else begin
            scr_q <= scr_d;
        end
    end
    assign fp_status_control_reg_q = scr_q;

    // apb: one wait state, so read data and error are registered
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= apb_acc & ~pready_q;
            prdata_q <= (apb_acc && !pready_q && !pwrite && apb_hit) ? scr_q : 32'h0000_0000;
            pslverr_q <= apb_acc & ~pready_q & ~apb_hit;
        end
    end

    // result registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            done_q <= 1'b0;
            unimp_q <= 1'b0;
            wb_gpr_we_q <= 1'b0;
            wb_lo_only_q <= 1'b0;
            wb_gpr_idx_q <= 5'h00;
            wb_gpr_data_q <= 64'h0000_0000_0000_0000;
            wb_cr_we_q <= 1'b0;
            wb_cr_field_q <= 3'h0;
            wb_cr_data_q <= 4'h0;
            data_irq_q <= 1'b0;
            round_irq_q <= 1'b0;
        end else begin
            done_q <= iss_valid;
            unimp_q <= iss_valid & (op == OP_NONE);
            wb_gpr_we_q <= iss_valid & gpr_we_d;
            wb_lo_only_q <= is_sadd | (op == OP_SABS);
            wb_gpr_idx_q <= iss_instr[RD_HI:RD_LO];
            wb_gpr_data_q <= arith ? ar_res : sop_res;
            wb_cr_we_q <= iss_valid & tst_op;
            wb_cr_field_q <= iss_instr[CRF_HI:CRF_LO];
            wb_cr_data_q <= 4'(cl) << CR_TEST_BIT;
            data_irq_q <= iss_valid & data_irq_d;
            round_irq_q <= iss_valid & round_irq_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_nabs;
        iss_valid && op == OP_DNABS && !sop_inv |=> wb_gpr_we_q && wb_gpr_data_q == {1'b1, $past(iss_opa[DP_EXP_HI:0])};
    endproperty
    a_nabs: assert property (p_nabs) else $error("nabs result wrong");

    property p_neg;
        iss_valid && op == OP_DNEG && !sop_inv |=> wb_gpr_data_q == ($past(iss_opa) ^ DP_SMASK);
    endproperty
    a_neg: assert property (p_neg) else $error("negate result wrong");

    property p_sabs;
        iss_valid && op == OP_SABS && !sop_inv |=> wb_lo_only_q && !wb_gpr_data_q[SP_SIGN];
    endproperty
    a_sabs: assert property (p_sabs) else $error("single abs sign set");

    property p_gx_clear;
        iss_valid && gx_clear |=> !scr_q[B_G] && !scr_q[B_X];
    endproperty
    a_gx_clear: assert property (p_gx_clear) else $error("guard bits not cleared");

    property p_inx;
        iss_valid && arith && !ar_inv && raw_ovf && !ovf_en |=> scr_q[B_INXS] && scr_q[B_OVF];
    endproperty
    a_inx: assert property (p_inx) else $error("inexact sticky missed");

    property p_round;
        iss_valid && round_irq_d |=> round_irq_q && wb_gpr_we_q && !data_irq_q;
    endproperty
    a_round: assert property (p_round) else $error("round interrupt path wrong");

    property p_inv_nowrite;
        iss_valid && is_dsub && (cls_a[0] || cls_b[0]) && inv_en |=> data_irq_q && !wb_gpr_we_q && scr_q[B_INV];
    endproperty
    a_inv_nowrite: assert property (p_inv_nowrite) else $error("invalid subtract wrote");

    property p_irq_nowrite;
        data_irq_q |-> !wb_gpr_we_q;
    endproperty
    a_irq_nowrite: assert property (p_irq_nowrite) else $error("write during interrupt");

    property p_unf_zero;
        iss_valid && is_dsub && ar_unf && !unf_en && rnd_minus |=> wb_gpr_data_q == DP_SMASK;
    endproperty
    a_unf_zero: assert property (p_unf_zero) else $error("underflow zero sign wrong");

    property p_sat_a;
        iss_valid && is_dsub && a_ni && !inv_en |=> wb_gpr_data_q[DP_EXP_HI:0] == DP_PMAX[DP_EXP_HI:0];
    endproperty
    a_sat_a: assert property (p_sat_a) else $error("saturation missing");

    property p_tst_quiet;
        iss_valid && tst_op && !apb_done |=> scr_q == $past(scr_q) && !data_irq_q && !round_irq_q;
    endproperty
    a_tst_quiet: assert property (p_tst_quiet) else $error("test changed status");

    property p_zero_eq;
        iss_valid && op == OP_DTSTEQ && iss_opa == DP_SMASK && iss_opb == 64'h0000_0000_0000_0000
            |=> wb_cr_we_q && wb_cr_data_q[CR_TEST_BIT];
    endproperty
    a_zero_eq: assert property (p_zero_eq) else $error("signed zeros unequal");

    c_sub_ok: cover property (iss_valid && is_dsub && gpr_we_d);
    c_round: cover property (round_irq_q);
    c_tst_true: cover property (wb_cr_we_q && wb_cr_data_q[CR_TEST_BIT]);
    c_apb_wr: cover property (apb_done && pwrite);
endmodule

// >>> esfp_unit_test.sv
// Purpose: self-checking bench for the sign, subtract, test and single add unit
// Assumes: one-cycle writeback, apb with one wait state
// Notes: driver queues expectations, a negedge monitor pops and compares
`timescale 1ns/1ps
module esfp_unit_test;
    import esfp_pkg::*;
    typedef struct packed {
        logic we; logic lo; logic [63:0] d; logic cw; logic [3:0] cr; logic [4:0] ix;
        logic di; logic ri; logic un; logic [31:0] scr; logic [31:0] msk;
    } esfp_exp_t;
    logic core_clk = 0;
    logic rst = 1;
    logic iss_valid = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [31:0] iss_instr = 0;
    logic [31:0] pwdata = 0;
    logic [63:0] iss_opa = 0;
    logic [63:0] iss_opb = 0;
    logic [11:0] paddr = 0;
    logic done_q, unimp_q, wb_gpr_we_q, wb_lo_only_q, wb_cr_we_q, data_irq_q, round_irq_q, pready_q, pslverr_q, err;
    logic [4:0] wb_gpr_idx_q;
    logic [63:0] wb_gpr_data_q;
    logic [2:0] wb_cr_field_q;
    logic [3:0] wb_cr_data_q;
    logic [31:0] fp_status_control_reg_q, prdata_q, scr_e, rd;
    logic [5:0] pop_v = PRIMARY_OP;
    logic [63:0] a, b;
    int error_cnt = 0;
    int checks_done = 0;
    esfp_exp_t expq[$];
    esfp_exp_t cur, ex, pv;
    always #20 core_clk = ~core_clk;
    esfp_unit dut (.core_clk(core_clk), .rst(rst), .iss_valid(iss_valid), .iss_instr(iss_instr),
        .iss_opa(iss_opa), .iss_opb(iss_opb), .done_q(done_q), .unimp_q(unimp_q), .wb_gpr_we_q(wb_gpr_we_q),
        .wb_lo_only_q(wb_lo_only_q), .wb_gpr_idx_q(wb_gpr_idx_q), .wb_gpr_data_q(wb_gpr_data_q),
        .wb_cr_we_q(wb_cr_we_q), .wb_cr_field_q(wb_cr_field_q), .wb_cr_data_q(wb_cr_data_q),
        .data_irq_q(data_irq_q), .round_irq_q(round_irq_q), .fp_status_control_reg_q(fp_status_control_reg_q),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q));
    esfp_core_model core (.core_clk(core_clk), .rst(rst), .wb_gpr_we_q(wb_gpr_we_q), .wb_lo_only_q(wb_lo_only_q),
        .wb_gpr_idx_q(wb_gpr_idx_q), .wb_gpr_data_q(wb_gpr_data_q), .wb_cr_we_q(wb_cr_we_q),
        .wb_cr_field_q(wb_cr_field_q), .wb_cr_data_q(wb_cr_data_q));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge core_clk);
        iss_valid <= 1'b0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready_q !== 1'b1);
        rd = prdata_q;
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // status write; bench mirror follows the writable bits only
    task automatic ws(input logic [31:0] v);
        apb(1'b1, SCR_ADDR, v);
        scr_e = v & SCR_WMASK;
    endtask
    task automatic iss(input logic [10:0] xo, input logic [63:0] oa, input logic [63:0] ob, input esfp_exp_t e);
        @(posedge core_clk);
        e.ix = 5'($urandom);
        iss_valid <= 1'b1;
        iss_instr <= {pop_v, e.ix, 10'h000, xo};
        iss_opa <= oa;
        iss_opb <= ob;
        expq.push_back(e);
    endtask
    function automatic esfp_exp_t gp(input logic [63:0] d, input logic lo, input logic [31:0] m);
        esfp_exp_t e;
        e = '0;
        e.we = 1'b1;
        e.d = d;
        e.lo = lo;
        e.scr = scr_e;
        e.msk = m;
        return e;
    endfunction
    function automatic esfp_exp_t nw(input logic di, input logic un, input logic cw, input logic cl);
        esfp_exp_t e;
        e = gp(64'h0, 1'b0, 32'hFFFF_FFFF);
        e.we = 1'b0;
        e.di = di;
        e.un = un;
        e.cw = cw;
        e.cr = {1'b0, cl, 2'b00};
        return e;
    endfunction
    function automatic logic gtf(input logic [63:0] x, input logic [63:0] y);
        if (x[62:0] == 0 && y[62:0] == 0) return 1'b0;
        if (x[63] != y[63]) return !x[63];
        return x[63] ? (x[62:0] < y[62:0]) : (x[62:0] > y[62:0]);
    endfunction

    always @(negedge core_clk) begin
        if (done_q === 1'b1) begin
            if (expq.size() == 0) begin
                chk(1, 0);
            end else begin
                if (pv.we) chk(core.gpr_q[pv.ix] & (pv.lo ? SP_LOMASK : '1), pv.d);
                if (pv.cw) chk(core.cr_q[4*pv.ix[4:2]+2], pv.cr[2]);
                cur = expq.pop_front();
                pv = cur;
                chk(wb_gpr_we_q, cur.we);
                chk(unimp_q, cur.un);
                chk(data_irq_q, cur.di);
                chk(round_irq_q, cur.ri);
                chk(wb_cr_we_q, cur.cw);
                chk(fp_status_control_reg_q & cur.msk, cur.scr & cur.msk);
                if (cur.we) chk({wb_lo_only_q, wb_gpr_idx_q, wb_gpr_data_q}, {cur.lo, cur.ix, cur.d});
                if (cur.cw) chk({wb_cr_field_q, wb_cr_data_q}, {cur.ix[4:2], cur.cr});
            end
        end
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        void'($urandom(32362));
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, SCR_ADDR, 32'h0);
        chk(rd, SCR_RESET);
        ws(32'hFFFF_FFFF);
        apb(1'b0, SCR_ADDR, 32'h0);
        chk(rd, SCR_WMASK);
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        ws(32'h0);
        // back-to-back sign ops and tests, zero pair first
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? DP_SMASK : {$urandom, $urandom};
            b = (i == 0) ? 64'h0 : ((i == 1) ? a : {$urandom, $urandom});
            iss(XO_DNABS, a, b, gp(a | DP_SMASK, 1'b0, 32'hFFFF_FFFF));
            iss(XO_DNEG, a, b, gp(a ^ DP_SMASK, 1'b0, 32'hFFFF_FFFF));
            iss(XO_SABS, a, b, gp(a & SP_LOMASK & ~SP_SMASK, 1'b1, 32'hFFFF_FFFF));
            iss(XO_DTSTEQ, a, b, nw(0, 0, 1, a === b || (a[62:0] == 0 && b[62:0] == 0)));
            iss(XO_DTSTGT, a, b, nw(0, 0, 1, gtf(a, b)));
            iss(XO_DTSTLT, a, b, nw(0, 0, 1, gtf(b, a)));
        end
        iss(XO_DSUB, 64'h4008_0000_0000_0000, 64'h3FF0_0000_0000_0000, gp(64'h4000_0000_0000_0000, 0, '1));
        scr_e = 32'h8;
        iss(XO_DSUB, 64'h3FF0_0000_0000_0000, 64'h3C90_0000_0000_0000, gp(64'h3FEF_FFFF_FFFF_FFFF, 0, ~32'h30));
        scr_e = 32'hA;
        iss(XO_DSUB, DP_PMAX, DP_PMAX | DP_SMASK, gp(DP_PMAX, 0, '1));
        scr_e = 32'hE;
        iss(XO_DSUB, 64'h0010_0000_0000_0001, 64'h0010_0000_0000_0000, gp(64'h0, 0, '1));
        ws(32'h3000);
        scr_e = 32'h3004;
        iss(XO_DSUB, 64'h0010_0000_0000_0001, 64'h0010_0000_0000_0000, gp(DP_SMASK, 0, '1));
        ws(32'h100);
        scr_e = 32'h101;
        iss(XO_DSUB, 64'h7FF0_0000_0000_0000, 64'h3FF0_0000_0000_0000, nw(1, 0, 0, 0));
        ws(32'h0);
        scr_e = 32'h1;
        iss(XO_DSUB, 64'h3FF0_0000_0000_0000, 64'h7FF8_0000_0000_0000, gp(DP_PMAX | DP_SMASK, 0, '1));
        iss(XO_DSUB, 64'hFFF0_0000_0000_0000, 64'h3FF0_0000_0000_0000, gp(DP_PMAX | DP_SMASK, 0, '1));
        ws(32'h800);
        scr_e = 32'h808;
        ex = gp(64'h3FEF_FFFF_FFFF_FFFF, 0, ~32'h30);
        ex.ri = 1'b1;
        iss(XO_DSUB, 64'h3FF0_0000_0000_0000, 64'h3C90_0000_0000_0000, ex);
        ws(32'h200);
        scr_e = 32'h202;
        iss(XO_DSUB, DP_PMAX, DP_PMAX | DP_SMASK, nw(1, 0, 0, 0));
        ws(32'h400);
        scr_e = 32'h404;
        iss(XO_DSUB, 64'h0010_0000_0000_0001, 64'h0010_0000_0000_0000, nw(1, 0, 0, 0));
        ws(32'h0);
        iss(XO_SADD, {$urandom, 32'h3F80_0000}, {$urandom, 32'h3F80_0000}, gp(64'h4000_0000, 1, '1));
        scr_e = 32'hA;
        iss(XO_SADD, 64'h7F7F_FFFF, 64'h7F7F_FFFF, gp(SP_PMAX, 1, '1));
        scr_e = 32'hB;
        iss(XO_SADD, 64'hFF80_0000, 64'hBF80_0000, gp(SP_PMAX | SP_SMASK, 1, '1));
        scr_e = 32'hF;
        iss(XO_SADD, 64'h0080_0001, 64'h8080_0000, gp(64'h0, 1, '1));
        ws(32'h4100);
        scr_e = 32'h4101;
        iss(XO_DNEG, 64'h7FF0_0000_0000_0000, 64'h0, nw(1, 0, 0, 0));
        ws(32'h4000);
        scr_e = 32'h4001;
        iss(XO_DNABS, 64'h1, 64'h0, gp(DP_SMASK | 64'h1, 0, '1));
        iss(11'h000, 64'h1, 64'h1, nw(0, 1, 0, 0));
        pop_v = 6'h05;
        iss(XO_DSUB, 64'h1, 64'h1, nw(0, 1, 0, 0));
        apb(1'b0, SCR_ADDR, 32'h0);
        chk(rd, scr_e);
        chk(expq.size(), 0);
        give_verdict();
    end
endmodule
